// ---- src/csp_pkg.sv ----
// Purpose: Shared constants and types of the clock source and prescaler block
// Assumes: 32-bit classic Wishbone register access, word aligned
// Notes: Field positions follow the register layout used by csp_top
package csp_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] CSP_MAIN_CTRL_OFF = 8'h00;
  localparam logic [7:0] CSP_CLK_SEL_OFF = 8'h04;
  localparam logic [7:0] CSP_OSC0_CFG_OFF = 8'h08;
  localparam logic [7:0] CSP_OSC1_CFG_OFF = 8'h0C;
  localparam logic [7:0] CSP_SLOW_CFG_OFF = 8'h10;
  localparam logic [7:0] CSP_LOOP0_OFF = 8'h14;
  localparam logic [7:0] CSP_LOOP1_OFF = 8'h18;
  localparam logic [7:0] CSP_STATUS_OFF = 8'h1C;
  localparam logic [7:0] CSP_EVENT_OFF = 8'h20;
  localparam logic [7:0] CSP_RC_TRIM_OFF = 8'h24;

  // ==========================================================
  // Writable bit masks (reset value of every register is zero except RC trim, loaded from the fuses, and status, which reads 0x20 with the done flag high)
  localparam logic [31:0] CSP_MAIN_CTRL_MASK = 32'h0000000F;
  localparam logic [31:0] CSP_CLK_SEL_MASK = 32'h87870087;
  localparam logic [31:0] CSP_OSC_CFG_MASK = 32'h00000F01;
  localparam logic [31:0] CSP_SLOW_CFG_MASK = 32'h00000F03;
  localparam logic [31:0] CSP_LOOP_MASK = 32'h00FF0F33;
  localparam logic [31:0] CSP_EVENT_MASK = 32'h0000003F;
  localparam logic [31:0] CSP_RC_TRIM_MASK = 32'h000000FF;

  // ==========================================================
  // Field positions
  localparam int CSP_SRC_LSB = 0;
  localparam int CSP_OSC0_ON_BIT = 2;
  localparam int CSP_OSC1_ON_BIT = 3;
  localparam int CSP_CPU_SEL_LSB = 0;
  localparam int CSP_CPU_DIV_BIT = 7;
  localparam int CSP_BUS_SEL_LSB = 8;
  localparam int CSP_BUS_DIV_BIT = 15;
  localparam int CSP_PBA_SEL_LSB = 16;
  localparam int CSP_PBA_DIV_BIT = 23;
  localparam int CSP_PBB_SEL_LSB = 24;
  localparam int CSP_PBB_DIV_BIT = 31;
  localparam int CSP_STAT_SWITCH_BIT = 5;
  localparam int CSP_STAT_RC_BIT = 6;

  // ==========================================================
  // Main clock source codes
  localparam logic [1:0] CSP_SRC_SLOW = 2'h0;
  localparam logic [1:0] CSP_SRC_OSC0 = 2'h1;
  localparam logic [1:0] CSP_SRC_LOOP0 = 2'h2;

  // ==========================================================
  // Timing constants
  localparam logic [1:0] CSP_RC_START_TICKS = 2'h3;
  localparam logic [3:0] CSP_SWITCH_GAP = 4'h8;
  localparam logic [7:0] CSP_PRESC_WRAP = 8'hFF;
  localparam logic [7:0] CSP_LOCK_BLANK = 8'h40;

  // ==========================================================
  // Register images
  typedef struct packed {
    logic [19:0] rsvd_hi;
    logic [3:0] startup;
    logic [6:0] rsvd_lo;
    logic mode;
  } csp_osc_cfg_t;

  typedef struct packed {
    logic [7:0] rsvd_hi;
    logic [7:0] multiplier;
    logic [3:0] rsvd_mid;
    logic [3:0] divider;
    logic [1:0] rsvd_opt;
    logic [1:0] options;
    logic [1:0] rsvd_lo;
    logic ref_select;
    logic on;
  } csp_loop_cfg_t;

  typedef struct packed {
    logic [8:0] ratio_num;
    logic [3:0] ratio_den;
    logic halve;
  } csp_loop_drive_t;

  typedef enum logic [2:0] {
    CSP_SW_IDLE = 3'b001,
    CSP_SW_DRAIN = 3'b010,
    CSP_SW_SWAP = 3'b100
  } csp_sw_state_t;
endpackage

// ---- src/csp_top.sv ----
// Purpose: Oscillator control, main clock selection and synchronous prescaler
// Assumes: rc_tick marks one slow RC oscillator cycle in the sys_clk domain
// Notes: Synchronous clocks leave as clock enables of the main clock model
`timescale 1ns/10ps
`default_nettype none
module csp_top
  import csp_pkg::*;
(
  input wire logic sys_clk, // System clock, 125 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic por, // Power-on reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic rc_tick, // One pulse per RC cycle
  input wire logic sleep_osc_stop, // Sleep stops main oscillators
  input wire logic sleep_static, // Static sleep, RC oscillator and slow crystal off
  input wire logic [1:0] loop_lock_raw, // Analog lock of each loop
  input wire logic [7:0] rc_trim_fuses, // Factory RC trim
  output logic rc_run, // RC oscillator enable
  output logic rc_ready, // RC oscillator usable
  output logic [7:0] rc_trim, // RC trim to oscillator
  output logic [1:0] osc_enable, // Main oscillator enables
  output logic [1:0] osc_crystal_mode, // 1 crystal, 0 external clock
  output logic [1:0] osc_gate, // Oscillator clock released
  output logic [1:0] xin_free, // Input pin free for I/O
  output logic [1:0] crystal_out_pin_free, // Output pin free for I/O
  output logic slow_crystal_enable, // Slow crystal enable
  output logic slow_crystal_gate, // Slow crystal clock released
  output logic [1:0] loop_enable, // Loop enables
  output logic [1:0] loop_ref, // Loop reference select
  output csp_loop_drive_t [1:0] loop_drive, // Loop ratio to analog
  output logic [1:0] loop_gate, // Loop clock released
  output logic [1:0] main_source, // Main clock source in use
  output logic main_gate, // Main clock released
  output logic cpu_clk_en, // Core clock enable
  output logic hsb_clk_en, // High speed bus clock enable
  output logic pba_clk_en, // Peripheral bus A clock enable
  output logic pbb_clk_en, // Peripheral bus B clock enable
  output logic clock_switch_done // New clock setting in effect
);
  // ==========================================================
  // Register state
  logic [31:0] main_clock_control_q;
  logic [31:0] clock_select_register_q;
  logic [31:0] clk_active_q;
  csp_osc_cfg_t [1:0] main_osc_config_q;
  logic [31:0] slow_crystal_config_q;
  csp_loop_cfg_t [1:0] loop_cfg_q;
  logic [31:0] event_q;
  logic [7:0] rc_trim_register_q;
  logic trim_loaded_q;
  logic [1:0] rc_cnt_q;
  logic [1:0] main_osc_stable_q;
  logic [15:0] osc_cnt_q [1:0];
  logic [15:0] slow_cnt_q;
  logic slow_crystal_stable_q;
  logic [1:0] loop_locked_q;
  logic [7:0] lock_cnt_q [1:0];
  logic [7:0] presc_q;
  logic tap_pending_q;
  csp_sw_state_t sw_state_q;
  logic [3:0] gap_q;
  logic [1:0] src_req_q;
  logic [5:0] status_prev_q;

  // Bus decode
  logic wr_stb;
  logic rd_stb;
  logic [31:0] byte_mask;
  logic [31:0] status_word;
  logic [31:0] sel_view;
  logic [4:0] rise_ev;
  logic src_ready;

  // Byte lane merge of write data
  function automatic logic [31:0] csp_merge(input logic [31:0] old_v, input logic [31:0] msk,
                                            input logic [31:0] wmask);
    csp_merge = (old_v & ~(msk & wmask)) | (wb_dat_i & msk & wmask);
  endfunction

  // Tap fires when low bits sel..0 all ones
  function automatic logic csp_tap(input logic div, input logic [2:0] sel, input logic [7:0] cnt);
    logic [8:0] span;
    span = (9'h002 << sel) - 9'h001;
    csp_tap = ~div | (&(cnt | ~span[7:0]));
  endfunction

  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Bus fields mirror core fields
  assign sel_view = {clock_select_register_q[31:16], clock_select_register_q[7:0],
                     clock_select_register_q[7:0]};
  assign status_word = {25'h0, rc_ready, clock_switch_done, slow_crystal_stable_q,
                        loop_locked_q, main_osc_stable_q};
  assign rise_ev = status_word[4:0] & ~status_prev_q[4:0];

  // ==========================================================
  // Wishbone acknowledge and read data
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (rd_stb)
      begin
        case (wb_adr_i)
          CSP_MAIN_CTRL_OFF: wb_dat_o <= main_clock_control_q;
          CSP_CLK_SEL_OFF: wb_dat_o <= sel_view;
          CSP_OSC0_CFG_OFF: wb_dat_o <= main_osc_config_q[0];
          CSP_OSC1_CFG_OFF: wb_dat_o <= main_osc_config_q[1];
          CSP_SLOW_CFG_OFF: wb_dat_o <= slow_crystal_config_q;
          CSP_LOOP0_OFF: wb_dat_o <= loop_cfg_q[0];
          CSP_LOOP1_OFF: wb_dat_o <= loop_cfg_q[1];
          CSP_STATUS_OFF: wb_dat_o <= status_word;
          CSP_EVENT_OFF: wb_dat_o <= event_q;
          CSP_RC_TRIM_OFF: wb_dat_o <= {24'h000000, rc_trim_register_q};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================================
  // Control registers on system reset
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      main_clock_control_q <= 32'h00000000;
      clock_select_register_q <= 32'h00000000;
      main_osc_config_q <= '0;
      loop_cfg_q <= '0;
    end
    else if (wr_stb)
    begin
      case (wb_adr_i)
        CSP_MAIN_CTRL_OFF:
          main_clock_control_q <= csp_merge(main_clock_control_q, CSP_MAIN_CTRL_MASK,
                                            byte_mask);
        CSP_CLK_SEL_OFF:
          clock_select_register_q <= csp_merge(clock_select_register_q, CSP_CLK_SEL_MASK,
                                               byte_mask & 32'hFFFF00FF);
        CSP_OSC0_CFG_OFF:
          main_osc_config_q[0] <= csp_merge(main_osc_config_q[0], CSP_OSC_CFG_MASK, byte_mask);
        CSP_OSC1_CFG_OFF:
          main_osc_config_q[1] <= csp_merge(main_osc_config_q[1], CSP_OSC_CFG_MASK, byte_mask);
        CSP_LOOP0_OFF:
          loop_cfg_q[0] <= csp_merge(loop_cfg_q[0], CSP_LOOP_MASK, byte_mask);
        CSP_LOOP1_OFF:
          loop_cfg_q[1] <= csp_merge(loop_cfg_q[1], CSP_LOOP_MASK, byte_mask);
        default:
        begin
        end
      endcase
    end
  end

  // Slow crystal setup kept across all but power-on
  always_ff @(posedge sys_clk or posedge por)
  begin
    if (por)
      slow_crystal_config_q <= 32'h00000000;
    else if (wr_stb && wb_adr_i == CSP_SLOW_CFG_OFF)
      slow_crystal_config_q <= csp_merge(slow_crystal_config_q, CSP_SLOW_CFG_MASK, byte_mask);
  end

  // ==========================================================
  // Rising edge event flags, write one to clear, set wins
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      event_q <= 32'h00000000;
      status_prev_q <= 6'h20; // Done flag idles high
    end
    else
    begin
      status_prev_q <= status_word[5:0];
      event_q <= ((wr_stb && wb_adr_i == CSP_EVENT_OFF) ?
                  (event_q & ~(wb_dat_i & byte_mask & CSP_EVENT_MASK)) : event_q)
                 | {26'h0, clock_switch_done & ~status_prev_q[5], rise_ev};
    end
  end

  // ==========================================================
  // RC oscillator, start-up and trim
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rc_run <= 1'b1;
      rc_ready <= 1'b0;
      rc_cnt_q <= 2'h0;
      rc_trim_register_q <= 8'h00;
      trim_loaded_q <= 1'b0;
      rc_trim <= 8'h00;
    end
    else
    begin
      rc_run <= ~sleep_static;
      if (sleep_static)
        rc_cnt_q <= 2'h0;
      else if (rc_tick && rc_cnt_q != CSP_RC_START_TICKS)
        rc_cnt_q <= rc_cnt_q + 2'h1;
      rc_ready <= ~sleep_static & (rc_cnt_q == CSP_RC_START_TICKS);
      trim_loaded_q <= 1'b1;
      if (!trim_loaded_q)
        rc_trim_register_q <= rc_trim_fuses;
      else if (wr_stb && wb_adr_i == CSP_RC_TRIM_OFF && wb_sel_i[0])
        rc_trim_register_q <= wb_dat_i[7:0];
      rc_trim <= rc_trim_register_q;
    end
  end

  // ==========================================================
  // Main oscillators and loops, one slice each
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_unit
      logic osc_on;
      logic [15:0] osc_target;
      assign osc_on = main_clock_control_q[CSP_OSC0_ON_BIT + gi] & ~sleep_osc_stop;
      assign osc_target = 16'h0001 << main_osc_config_q[gi].startup;

      // Start-up masking restarts on every stop
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          osc_cnt_q[gi] <= 16'h0000;
          main_osc_stable_q[gi] <= 1'b0;
          osc_enable[gi] <= 1'b0;
          osc_crystal_mode[gi] <= 1'b0;
          osc_gate[gi] <= 1'b0;
          xin_free[gi] <= 1'b1;
          crystal_out_pin_free[gi] <= 1'b1;
        end
        else
        begin
          if (!osc_on)
            osc_cnt_q[gi] <= 16'h0000;
          else if (rc_tick && osc_cnt_q[gi] != osc_target)
            osc_cnt_q[gi] <= osc_cnt_q[gi] + 16'h0001;
          main_osc_stable_q[gi] <= osc_on & (osc_cnt_q[gi] == osc_target);
          osc_gate[gi] <= main_osc_stable_q[gi];
          osc_enable[gi] <= osc_on;
          osc_crystal_mode[gi] <= main_osc_config_q[gi].mode;
          xin_free[gi] <= ~main_clock_control_q[CSP_OSC0_ON_BIT + gi];
          crystal_out_pin_free[gi] <= ~main_clock_control_q[CSP_OSC0_ON_BIT + gi]
                           | ~main_osc_config_q[gi].mode;
        end
      end

      // Loop lock blanking after enable or retune
      logic loop_on;
      logic retune;
      logic [8:0] mul_plus;
      csp_loop_cfg_t cfg_prev_q;
      assign loop_on = loop_cfg_q[gi].on & ~sleep_osc_stop;
      assign retune = (loop_on & ~cfg_prev_q.on)
                      | (loop_cfg_q[gi].ref_select != cfg_prev_q.ref_select)
                      | (loop_cfg_q[gi].multiplier != cfg_prev_q.multiplier)
                      | (loop_cfg_q[gi].divider != cfg_prev_q.divider);
      assign mul_plus = {1'b0, loop_cfg_q[gi].multiplier} + 9'h001;

      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          cfg_prev_q <= '0;
          lock_cnt_q[gi] <= 8'h00;
          loop_locked_q[gi] <= 1'b0;
          loop_gate[gi] <= 1'b0;
          loop_enable[gi] <= 1'b0;
          loop_ref[gi] <= 1'b0;
          loop_drive[gi] <= '0;
        end
        else
        begin
          cfg_prev_q <= loop_cfg_q[gi];
          cfg_prev_q.on <= loop_on;
          if (!loop_on || retune)
            lock_cnt_q[gi] <= CSP_LOCK_BLANK;
          else if (lock_cnt_q[gi] != 8'h00)
            lock_cnt_q[gi] <= lock_cnt_q[gi] - 8'h01;
          loop_locked_q[gi] <= loop_on & ~retune & (lock_cnt_q[gi] == 8'h00)
                               & loop_lock_raw[gi];
          loop_gate[gi] <= loop_locked_q[gi];
          loop_enable[gi] <= loop_on;
          loop_ref[gi] <= loop_cfg_q[gi].ref_select;
          if (loop_cfg_q[gi].divider == 4'h0)
          begin
            loop_drive[gi].ratio_num <= {mul_plus[7:0], 1'b0};
            loop_drive[gi].ratio_den <= 4'h1;
          end
          else
          begin
            loop_drive[gi].ratio_num <= mul_plus;
            loop_drive[gi].ratio_den <= loop_cfg_q[gi].divider;
          end
          loop_drive[gi].halve <= loop_cfg_q[gi].options[1];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Slow crystal, survives system reset
  logic [15:0] slow_target;
  logic slow_on;
  assign slow_target = 16'h0001 << slow_crystal_config_q[11:8];
  assign slow_on = slow_crystal_config_q[0] & ~sleep_static;

  always_ff @(posedge sys_clk or posedge por)
  begin
    if (por)
    begin
      slow_cnt_q <= 16'h0000;
      slow_crystal_stable_q <= 1'b0;
      slow_crystal_enable <= 1'b0;
      slow_crystal_gate <= 1'b0;
    end
    else
    begin
      if (!slow_on)
        slow_cnt_q <= 16'h0000;
      else if (rc_tick && slow_cnt_q != slow_target)
        slow_cnt_q <= slow_cnt_q + 16'h0001;
      slow_crystal_stable_q <= slow_on & (slow_cnt_q == slow_target);
      slow_crystal_enable <= slow_on;
      slow_crystal_gate <= slow_crystal_stable_q;
    end
  end

  // ==========================================================
  // Main source switch: gate off, drain, swap, wait ready
  always_comb
  begin
    case (src_req_q)
      CSP_SRC_OSC0: src_ready = main_osc_stable_q[0];
      CSP_SRC_LOOP0: src_ready = loop_locked_q[0];
      default: src_ready = rc_ready;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sw_state_q <= CSP_SW_IDLE;
      gap_q <= 4'h0;
      src_req_q <= CSP_SRC_SLOW;
      main_source <= CSP_SRC_SLOW;
      main_gate <= 1'b1;
    end
    else
    begin
      case (sw_state_q)
        CSP_SW_IDLE:
          if (main_clock_control_q[CSP_SRC_LSB +: 2] != main_source)
          begin
            src_req_q <= main_clock_control_q[CSP_SRC_LSB +: 2];
            main_gate <= 1'b0;
            gap_q <= CSP_SWITCH_GAP;
            sw_state_q <= CSP_SW_DRAIN;
          end
        CSP_SW_DRAIN:
          if (gap_q == 4'h0)
          begin
            main_source <= src_req_q;
            sw_state_q <= CSP_SW_SWAP;
          end
          else
            gap_q <= gap_q - 4'h1;
        CSP_SW_SWAP:
          if (src_ready)
          begin
            main_gate <= 1'b1;
            sw_state_q <= CSP_SW_IDLE;
          end
        default:
          sw_state_q <= CSP_SW_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Prescaler; taps retuned only at full wrap
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      presc_q <= 8'h00;
      clk_active_q <= 32'h00000000;
      tap_pending_q <= 1'b0;
      clock_switch_done <= 1'b1;
      cpu_clk_en <= 1'b0;
      hsb_clk_en <= 1'b0;
      pba_clk_en <= 1'b0;
      pbb_clk_en <= 1'b0;
    end
    else
    begin
      if (main_gate)
        presc_q <= presc_q + 8'h01;
      if (wr_stb && wb_adr_i == CSP_CLK_SEL_OFF)
        tap_pending_q <= 1'b1;
      else if (tap_pending_q && main_gate && presc_q == CSP_PRESC_WRAP)
      begin
        clk_active_q <= clock_select_register_q;
        tap_pending_q <= 1'b0;
      end
      clock_switch_done <= ~tap_pending_q & ~(wr_stb && wb_adr_i == CSP_CLK_SEL_OFF)
                           & (sw_state_q == CSP_SW_IDLE);
      cpu_clk_en <= main_gate & csp_tap(clk_active_q[CSP_CPU_DIV_BIT],
                    clk_active_q[CSP_CPU_SEL_LSB +: 3], presc_q);
      hsb_clk_en <= main_gate & csp_tap(clk_active_q[CSP_CPU_DIV_BIT],
                    clk_active_q[CSP_CPU_SEL_LSB +: 3], presc_q);
      pba_clk_en <= main_gate & csp_tap(clk_active_q[CSP_PBA_DIV_BIT],
                    clk_active_q[CSP_PBA_SEL_LSB +: 3], presc_q);
      pbb_clk_en <= main_gate & csp_tap(clk_active_q[CSP_PBB_DIV_BIT],
                    clk_active_q[CSP_PBB_SEL_LSB +: 3], presc_q);
    end
  end
endmodule
`default_nettype wire

// ---- bench/csp_top_sva.sv ----
// Purpose: Port checks of csp_top
// Assumes: One sys_clk domain
// Notes: Bound at the foot
`timescale 1ns/10ps
`default_nettype none
module csp_top_sva
  import csp_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic rst, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [7:0] wb_adr_i, // Address
  input wire logic wb_ack_o, // Ack
  input wire logic [1:0] osc_enable, // Osc on
  input wire logic [1:0] osc_gate, // Osc out
  input wire logic [1:0] xin_free, // Pin free
  input wire logic [1:0] loop_lock_raw, // Lock in
  input wire logic [1:0] loop_gate, // Loop out
  input wire logic [1:0] main_source, // Source
  input wire logic main_gate, // Main run
  input wire logic cpu_clk_en, // Core en
  input wire logic hsb_clk_en, // Bus en
  input wire logic clock_switch_done // Done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Bus answer and pulse
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack long");
  // Clock outputs
  property p_xin; xin_free[0] |-> !osc_enable[0]; endproperty
  a_xin: assert property (p_xin) else $error("pin busy");
  property p_osc; $rose(osc_gate[0]) |-> $past(osc_enable[0], 2); endproperty
  a_osc: assert property (p_osc) else $error("osc early");
  property p_loop; $rose(loop_gate[0]) |-> $past(loop_lock_raw[0], 2); endproperty
  a_loop: assert property (p_loop) else $error("loop early");
  property p_hsb; hsb_clk_en == cpu_clk_en; endproperty
  a_hsb: assert property (p_hsb) else $error("bus en");
  property p_main; $changed(main_source) |-> !main_gate; endproperty
  a_main: assert property (p_main) else $error("hot swap");
  property p_done;
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == CSP_CLK_SEL_OFF
      |=> ##1 !clock_switch_done;
  endproperty
  a_done: assert property (p_done) else $error("done high");
endmodule
bind csp_top csp_top_sva i_csp_top_sva (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
  .osc_enable(osc_enable), .osc_gate(osc_gate), .xin_free(xin_free), .main_gate(main_gate),
  .loop_lock_raw(loop_lock_raw), .loop_gate(loop_gate), .main_source(main_source),
  .cpu_clk_en(cpu_clk_en), .hsb_clk_en(hsb_clk_en), .clock_switch_done(clock_switch_done));
`default_nettype wire

// ---- bench/csp_osc_model.sv ----
// Purpose: RC oscillator and loop lock model
// Assumes: RC rate scaled down
// Notes: Lock after a fixed delay
`timescale 1ns/10ps
`default_nettype none
module csp_osc_model
  import csp_pkg::*;
#(parameter int RC_DIV = 8, parameter int LOCK_DLY = 90)
(
  input wire logic sys_clk, // Clock
  input wire logic [1:0] loop_enable, // Loop on
  output logic rc_tick = 1'h0, // RC cycle
  output logic [1:0] loop_lock_raw = 2'h0 // Lock
);
  int div_q = 0;
  int lk_q [2] = '{0, 0};
  // Free RC ticks, lock once settled
  always @(posedge sys_clk)
  begin
    div_q <= (div_q == RC_DIV - 1) ? 0 : div_q + 1;
    rc_tick <= (div_q == RC_DIV - 1);
    for (int i = 0; i < 2; i++)
    begin
      lk_q[i] <= loop_enable[i] ? ((lk_q[i] < LOCK_DLY) ? lk_q[i] + 1 : lk_q[i]) : 0;
      loop_lock_raw[i] <= loop_enable[i] && (lk_q[i] == LOCK_DLY);
    end
  end
endmodule
`default_nettype wire

// ---- bench/csp_top_tb.sv ----
// Purpose: Self-checking bench of csp_top
// Assumes: Wishbone answers in one cycle
// Notes: Sleep inputs driven
`timescale 1ns/10ps
`default_nettype none
module csp_top_tb
  import csp_pkg::*;
;
  logic sys_clk = 1'h0, rst = 1'h1, por = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, rc_tick, slow_crystal_enable, main_gate, cpu_clk_en, hsb_clk_en, pba_clk_en;
  logic [1:0] loop_lock_raw, osc_enable, osc_gate, xin_free, crystal_out_pin_free, loop_enable, loop_gate;
  logic [1:0] main_source, osc_crystal_mode, loop_ref;
  logic clock_switch_done, rc_run, rc_ready, slow_crystal_gate, pbb_clk_en;
  logic sleep_osc_stop = 1'h0, sleep_static = 1'h0;
  logic [7:0] rc_trim;
  csp_loop_drive_t [1:0] loop_drive;
  int error_cnt = 0, samples_checked = 0, n, c, p, b;
  csp_top i_csp_top (.sys_clk(sys_clk), .rst(rst), .por(por), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rc_tick(rc_tick),
    .sleep_osc_stop(sleep_osc_stop), .sleep_static(sleep_static), .loop_lock_raw(loop_lock_raw),
    .rc_trim_fuses(8'hA5), .rc_run(rc_run), .rc_ready(rc_ready), .rc_trim(rc_trim),
    .osc_enable(osc_enable), .osc_crystal_mode(osc_crystal_mode), .osc_gate(osc_gate),
    .xin_free(xin_free), .crystal_out_pin_free(crystal_out_pin_free), .slow_crystal_enable(slow_crystal_enable),
    .slow_crystal_gate(slow_crystal_gate), .loop_enable(loop_enable), .loop_ref(loop_ref),
    .loop_drive(loop_drive), .loop_gate(loop_gate), .main_source(main_source),
    .main_gate(main_gate), .cpu_clk_en(cpu_clk_en), .hsb_clk_en(hsb_clk_en),
    .pba_clk_en(pba_clk_en), .pbb_clk_en(pbb_clk_en), .clock_switch_done(clock_switch_done));
  csp_osc_model i_csp_osc_model (.sys_clk(sys_clk), .loop_enable(loop_enable),
    .rc_tick(rc_tick), .loop_lock_raw(loop_lock_raw));
  always #4 sys_clk = ~sys_clk;
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One classic Wishbone cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    do @(posedge sys_clk); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    @(posedge sys_clk);
  endtask
  // Count cpu, pba and pbb clock enables over 512 cycles into c, p, b
  task automatic cnt_en();
    c = 0;
    p = 0;
    b = 0;
    repeat (512)
    begin
      @(posedge sys_clk);
      c += cpu_clk_en;
      p += pba_clk_en;
      b += pbb_clk_en;
    end
  endtask
  task automatic t_regs();
    bus(1'h0, CSP_MAIN_CTRL_OFF, 32'h0);
    chk({q[25:0], xin_free, crystal_out_pin_free, main_source}, 32'h3C);
    bus(1'h0, CSP_RC_TRIM_OFF, 32'h0);
    chk(q, 32'hA5);
    bus(1'h0, 8'h30, 32'h0);
    chk(q, 32'h0);
    bus(1'h1, CSP_RC_TRIM_OFF, 32'h5A);
    @(posedge sys_clk);
    chk({24'h0, rc_trim}, 32'h5A);
  endtask
  task automatic t_presc();
    bus(1'h1, CSP_CLK_SEL_OFF, 32'hFFFFFFFF);
    for (n = 0; n < 600 && clock_switch_done !== 1'h1; n++) @(posedge sys_clk);
    chk({31'h0, clock_switch_done}, 32'h1);
    bus(1'h0, CSP_CLK_SEL_OFF, 32'h0);
    chk(q, 32'h87878787);
    cnt_en();
    chk({c[15:0], p[7:0], b[7:0]}, 32'h00020202);
    bus(1'h1, CSP_CLK_SEL_OFF, 32'h86870080);
    for (n = 0; n < 600 && clock_switch_done !== 1'h1; n++) @(posedge sys_clk);
    chk({31'h0, clock_switch_done}, 32'h1);
    cnt_en();
    chk({c[15:0], p[7:0], b[7:0]}, 32'h01000204);
  endtask
  task automatic t_osc();
    bus(1'h1, CSP_OSC0_CFG_OFF, 32'h201);
    bus(1'h1, CSP_MAIN_CTRL_OFF, 32'h4);
    for (n = 0; n < 600 && osc_gate[0] !== 1'h1; n++) @(posedge sys_clk);
    chk({26'h0, osc_gate[0], n > 16, xin_free, crystal_out_pin_free}, 32'h3A);
    chk({29'h0, rc_run, rc_ready, osc_crystal_mode[0]}, 32'h7);
    bus(1'h0, CSP_STATUS_OFF, 32'h0);
    chk(q & 32'h1, 32'h1);
    bus(1'h0, CSP_EVENT_OFF, 32'h0);
    chk(q, 32'h21);
    sleep_osc_stop <= 1'h1;
    repeat (3) @(posedge sys_clk);
    chk({30'h0, osc_enable[0], osc_gate[0]}, 32'h0);
    sleep_osc_stop <= 1'h0;
    for (n = 0; n < 600 && osc_gate[0] !== 1'h1; n++) @(posedge sys_clk);
    chk({30'h0, osc_gate[0], n > 16}, 32'h3);
    bus(1'h1, CSP_MAIN_CTRL_OFF, 32'h5);
    for (n = 0; n < 600 && {main_gate, main_source} !== 3'h5; n++) @(posedge sys_clk);
    chk({29'h0, main_gate, main_source}, 32'h5);
  endtask
  task automatic t_loop();
    bus(1'h1, CSP_LOOP0_OFF, 32'h00030021);
    chk({18'h0, loop_drive[0]}, 32'h103);
    for (n = 0; n < 900 && loop_gate[0] !== 1'h1; n++) @(posedge sys_clk);
    bus(1'h0, CSP_STATUS_OFF, 32'h0);
    chk({n > 60, q[30:0] & 31'h4}, 32'h80000004);
    bus(1'h1, CSP_LOOP0_OFF, 32'h00050303);
    @(posedge sys_clk);
    chk({16'h0, loop_ref[0], loop_gate[0], loop_drive[0]}, 32'h80C6);
  endtask
  task automatic t_slow();
    bus(1'h1, CSP_SLOW_CFG_OFF, 32'h1);
    rst <= 1'h1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'h0;
    bus(1'h0, CSP_SLOW_CFG_OFF, 32'h0);
    chk({q[30:0], slow_crystal_enable}, 32'h3);
    bus(1'h0, CSP_STATUS_OFF, 32'h0);
    chk({q[31:1] & 31'h8, slow_crystal_gate}, 32'h11);
    sleep_static <= 1'h1;
    repeat (2) @(posedge sys_clk);
    chk({29'h0, rc_run, rc_ready, slow_crystal_enable}, 32'h0);
    sleep_static <= 1'h0;
    por <= 1'h1;
    @(posedge sys_clk);
    por <= 1'h0;
    bus(1'h0, CSP_SLOW_CFG_OFF, 32'h0);
    chk(q, 32'h0);
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence and watchdog
  initial
  begin
    repeat (4) @(posedge sys_clk);
    {rst, por} <= 2'h0;
    t_regs();
    t_presc();
    t_osc();
    t_loop();
    t_slow();
    conclude();
  end
  initial
  begin
    #400000;
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
